//--- fpc_pkg.sv
// package for the flash program/erase controller: addresses, keys, codes, carriers
// assumes a byte-wide register port and a 16-bit program memory address space
`default_nettype none

package fpc_pkg;

	// register addresses on the 12-bit register port
	localparam logic [11:0] FPC_ADDR_CTRL = 12'hff8; // control writes, state reads
	localparam logic [11:0] FPC_ADDR_PAGE = 12'hff9; // page choice / sector protect

	// values written to the control address
	localparam logic [7:0] FPC_KEY_FIRST = 8'h73; // first unlock value
	localparam logic [7:0] FPC_KEY_SECOND = 8'h8c; // second unlock value
	localparam logic [7:0] FPC_KEY_PROT = 8'h5e; // selects sector protect
	localparam logic [7:0] FPC_CMD_ERASE = 8'h95; // page erase on active page

	// reset values
	localparam logic [7:0] FPC_PAGE_RST = 8'h00; // page choice after reset
	localparam logic [7:0] FPC_PROT_RST = 8'h00; // all sectors unprotected

	// field positions in the page choice register
	localparam int FPC_INFO_BIT = 7; // info area map enable
	localparam int FPC_PAGE_MSB = 6; // page field top bit
	localparam int FPC_PAGE_SHIFT = 9; // page field meets address bits 15:9

	// six-bit lock progress codes
	localparam logic [5:0] FPC_ST_LOCKED = 6'h00;
	localparam logic [5:0] FPC_ST_FIRST = 6'h01;
	localparam logic [5:0] FPC_ST_SECOND = 6'h02;
	localparam logic [5:0] FPC_ST_UNLOCKED = 6'h03;
	localparam logic [5:0] FPC_ST_PROT = 6'h04;

	// upper three status bits while an operation runs
	localparam logic [2:0] FPC_OP_PROG = 3'h1;
	localparam logic [2:0] FPC_OP_ERASE = 3'h2;
	localparam logic [2:0] FPC_OP_MASS = 3'h4;
	localparam logic [2:0] FPC_OP_NONE = 3'h0;

	// lock sequencer states
	typedef enum logic [2:0] {
		FPC_LOCKED,
		FPC_KEY1,
		FPC_KEY2,
		FPC_OPEN,
		FPC_PROT_SEL
	} fpc_state_type;

	// one register port access
	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [11:0] addr; // register address
		logic [7:0] wdata; // write data
	} fpc_bus_type;

	// command to the flash array, one-cycle strobes
	typedef struct packed {
		logic prog; // program one byte
		logic erase; // erase one page
		logic mass; // erase whole array
		logic [15:0] addr; // byte address or page base
		logic [7:0] data; // byte to program
	} fpc_cmd_type;

	// byte program request from core or debugger
	typedef struct packed {
		logic req; // one-cycle request
		logic [15:0] addr; // target byte address
		logic [7:0] data; // byte value
	} fpc_prog_type;

endpackage

`default_nettype wire

//--- fpc_sector_map.sv
// sector lookup: which protection sector holds an address, and is it protected
// assumes power-of-two array and page sizes; purely combinational
`default_nettype none

module fpc_sector_map #(
	parameter int MEM_BYTES = 8192, // flash array size
	parameter int PAGE_BYTES = 512 // flash page size
) (
	input wire logic [15:0] addr_i, // byte address to classify
	input wire logic [7:0] prot_i, // sector protect bits
	output logic locked_o // high when the sector is protected
);

	// an eighth of the array, but never below one page
	localparam int EIGHTH = MEM_BYTES / 8;
	localparam int SECTOR_BYTES = (EIGHTH < PAGE_BYTES) ? PAGE_BYTES : EIGHTH;
	localparam int SEC_SHIFT = $clog2(SECTOR_BYTES);

	// refuse sizes the shift-based lookup cannot serve
	initial
	begin
		if ((MEM_BYTES & (MEM_BYTES - 1)) != 0 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0
			|| MEM_BYTES > 65536 || MEM_BYTES < PAGE_BYTES)
			$error("fpc_sector_map: unsupported array or page size");
	end

	logic [15:0] shifted; // address divided by sector size
	logic [2:0] idx; // sector number, at most eight sectors

	always_comb
	begin
		shifted = addr_i >> SEC_SHIFT;
		idx = shifted[2:0];
		locked_o = prot_i[idx];
	end

endmodule

`default_nettype wire

//--- fpc_op_tracker.sv
// tracks the flash operation in progress and its kind
// assumes the array pulses done_i once per started operation, same clock
`default_nettype none

module fpc_op_tracker (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic [2:0] start_i, // one-hot kind, pulse on start
	input wire logic done_i, // array finished the operation
	output logic busy_o, // operation running
	output logic [2:0] kind_o // running kind for the status field
);

	logic busy_q; // running flag
	logic [2:0] kind_q; // kind of running operation

	// start sets, done clears; a start never overlaps a running operation
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_q <= 1'b0;
			kind_q <= fpc_pkg::FPC_OP_NONE;
		end
		else if (start_i != fpc_pkg::FPC_OP_NONE)
		begin
			busy_q <= 1'b1;
			kind_q <= start_i;
		end
		else if (done_i)
		begin
			busy_q <= 1'b0;
			kind_q <= fpc_pkg::FPC_OP_NONE;
		end
	end

	assign busy_o = busy_q;
	assign kind_o = kind_q;

endmodule

`default_nettype wire

//--- fpc_controller.sv
// flash program/erase controller: unlock sequence, page choice, sector protect,
// command strobes to the array and the readable controller state
// assumes the register port master, core and debugger all run on sys_clk_i
//
// Our own choice: the plain strobed port.
`default_nettype none

// Functional notes
// - 95H on unlocked unprotected page erases it
// - unrecognised control value returns to locked
// - whole-array erase only from debug port
// - unlocked page accepts byte programs, stays unlocked
// - later control write relocks the active page
// - eight sectors, each eighth, minimum one page
// - 73H then 5EH steers next write to protect
// - protect clears at reset, set bit blocks
// - protect bits never block debug programming
// - status codes zero to four show lock progress
// - upper status bits show running operation kind
// - page choice and protect share one address
// - erase covers address range of page field
// - page field compares address bits 15 to 9
// - page choice bit seven maps info area
// - controller leaves reset locked
// - page, two unlocks, same page; mismatch stays locked
module fpc_controller #(
	parameter int MEM_BYTES = 8192, // flash array size in bytes
	parameter int PAGE_BYTES = 512 // flash page size in bytes
) (
	input wire logic sys_clk_i, // system clock, 100 MHz
	input wire logic rst_n_i, // async reset, active low
	input wire fpc_pkg::fpc_bus_type bus_i, // register port access
	output logic [7:0] rdata_o, // read data, cycle after read strobe
	input wire fpc_pkg::fpc_prog_type cpu_prog_i, // core byte program request
	input wire fpc_pkg::fpc_prog_type dbg_prog_i, // debugger byte program request
	input wire logic dbg_mass_i, // debugger whole-array erase request
	input wire logic flash_done_i, // array finished current operation
	output fpc_pkg::fpc_cmd_type cmd_o, // command strobes to the array
	output logic info_map_o, // info area mapped into program space
	output logic busy_o // operation in progress
);

	// page field must reach exactly the address bits above one page
	initial
	begin
		if (PAGE_BYTES != (1 << fpc_pkg::FPC_PAGE_SHIFT) || MEM_BYTES > 65536)
			$error("fpc_controller: page size must match the page field");
	end

	fpc_pkg::fpc_state_type state_q; // lock sequencer state
	logic [7:0] page_q; // page choice register
	logic [7:0] prot_q; // sector protect register
	logic [7:0] rdata_q; // read data register
	fpc_pkg::fpc_cmd_type cmd_q; // registered array command
	logic info_q; // info area map output
	logic busy_q; // registered busy output
	logic trk_busy; // tracker busy flag
	logic [2:0] trk_kind; // tracker running kind
	logic [2:0] start; // one-hot start to tracker
	logic [5:0] status; // six-bit controller state field
	logic wr_ctrl; // write to control address
	logic wr_page; // write to shared page address
	logic rd_ctrl; // read of control address
	logic rd_page; // read of page address
	logic page_prot; // chosen page sits in a protected sector
	logic cpu_prot; // core target sits in a protected sector
	logic cpu_ok; // core program accepted
	logic dbg_ok; // debugger program accepted
	logic mass_ok; // debugger mass erase accepted
	logic erase_ok; // page erase accepted
	logic [15:0] page_base; // first byte of the chosen page

	// page field to byte address of page start
	function automatic logic [15:0] page_addr(input logic [7:0] pg);
		page_addr = {pg[fpc_pkg::FPC_PAGE_MSB:0], 9'h000};
	endfunction

	// address decode of the register port
	always_comb
	begin
		wr_ctrl = bus_i.wr && (bus_i.addr == fpc_pkg::FPC_ADDR_CTRL);
		wr_page = bus_i.wr && (bus_i.addr == fpc_pkg::FPC_ADDR_PAGE);
		rd_ctrl = bus_i.rd && (bus_i.addr == fpc_pkg::FPC_ADDR_CTRL);
		rd_page = bus_i.rd && (bus_i.addr == fpc_pkg::FPC_ADDR_PAGE);
	end

	// erase target is the page base
	assign page_base = page_addr(page_q);

	// protection lookup for the chosen page
	fpc_sector_map #(
		.MEM_BYTES(MEM_BYTES),
		.PAGE_BYTES(PAGE_BYTES)
	) u_page_sec (
		.addr_i(page_base),
		.prot_i(prot_q),
		.locked_o(page_prot)
	);

	// protection lookup for the core's program target
	fpc_sector_map #(
		.MEM_BYTES(MEM_BYTES),
		.PAGE_BYTES(PAGE_BYTES)
	) u_cpu_sec (
		.addr_i(cpu_prog_i.addr),
		.prot_i(prot_q),
		.locked_o(cpu_prot)
	);

	// acceptance of each operation
	always_comb
	begin
		// page field against address bits 15:9
		cpu_ok = cpu_prog_i.req && !trk_busy && (state_q == fpc_pkg::FPC_OPEN)
			&& (cpu_prog_i.addr[15:9] == page_q[fpc_pkg::FPC_PAGE_MSB:0]) && !cpu_prot;
		// debugger program ignores protect and lock
		dbg_ok = dbg_prog_i.req && !trk_busy && !cpu_ok;
		// erase needs open page in free sector
		// a program in the same cycle wins, so only one strobe ever fires
		erase_ok = wr_ctrl && (bus_i.wdata == fpc_pkg::FPC_CMD_ERASE)
			&& (state_q == fpc_pkg::FPC_OPEN) && !page_prot && !trk_busy
			&& !cpu_ok && !dbg_ok;
		// mass erase only through debug port
		mass_ok = dbg_mass_i && !trk_busy && !cpu_ok && !dbg_prog_i.req && !erase_ok;
		start = fpc_pkg::FPC_OP_NONE;
		if (cpu_ok || dbg_ok)
			start = fpc_pkg::FPC_OP_PROG;
		else if (erase_ok)
			start = fpc_pkg::FPC_OP_ERASE;
		else if (mass_ok)
			start = fpc_pkg::FPC_OP_MASS;
	end

	// operation in progress tracking
	fpc_op_tracker u_trk (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(start),
		.done_i(flash_done_i),
		.busy_o(trk_busy),
		.kind_o(trk_kind)
	);

	// lock sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= fpc_pkg::FPC_LOCKED;
		else if (wr_ctrl)
		begin
			case (state_q)
				fpc_pkg::FPC_LOCKED:
				begin
					if (bus_i.wdata == fpc_pkg::FPC_KEY_FIRST)
						state_q <= fpc_pkg::FPC_KEY1;
					else
						state_q <= fpc_pkg::FPC_LOCKED;
				end
				fpc_pkg::FPC_KEY1:
				begin
					// second value picks unlock or protect
					if (bus_i.wdata == fpc_pkg::FPC_KEY_SECOND)
						state_q <= fpc_pkg::FPC_KEY2;
					else if (bus_i.wdata == fpc_pkg::FPC_KEY_PROT)
						state_q <= fpc_pkg::FPC_PROT_SEL;
					else
						state_q <= fpc_pkg::FPC_LOCKED;
				end
				// any control write relocks open page
				fpc_pkg::FPC_OPEN:
					state_q <= fpc_pkg::FPC_LOCKED;
				default:
					state_q <= fpc_pkg::FPC_LOCKED;
			endcase
		end
		else if (wr_page)
		begin
			case (state_q)
				fpc_pkg::FPC_KEY2:
				begin
					// matching page rewrite opens the page
					if (bus_i.wdata == page_q)
						state_q <= fpc_pkg::FPC_OPEN;
					else
						state_q <= fpc_pkg::FPC_LOCKED;
				end
				// protect write ends the protect selection
				default:
					state_q <= fpc_pkg::FPC_LOCKED;
			endcase
		end
	end

	// shared address: page choice unless protect selected
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			page_q <= fpc_pkg::FPC_PAGE_RST;
		else if (wr_page && state_q != fpc_pkg::FPC_PROT_SEL)
			page_q <= bus_i.wdata;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prot_q <= fpc_pkg::FPC_PROT_RST;
		else if (wr_page && state_q == fpc_pkg::FPC_PROT_SEL)
			// next shared write lands in protect
			prot_q <= bus_i.wdata;
	end

	always_comb
	begin
		case (state_q)
			fpc_pkg::FPC_KEY1:
				status = fpc_pkg::FPC_ST_FIRST;
			fpc_pkg::FPC_KEY2:
				status = fpc_pkg::FPC_ST_SECOND;
			fpc_pkg::FPC_OPEN:
				status = fpc_pkg::FPC_ST_UNLOCKED;
			fpc_pkg::FPC_PROT_SEL:
				status = fpc_pkg::FPC_ST_PROT;
			default:
				status = fpc_pkg::FPC_ST_LOCKED;
		endcase
		if (trk_busy)
			status = {trk_kind, 3'h0};
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 8'h00;
		else if (rd_ctrl)
			rdata_q <= {2'h0, status};
		else if (rd_page)
			rdata_q <= (state_q == fpc_pkg::FPC_PROT_SEL) ? prot_q : page_q;
		else
			rdata_q <= 8'h00;
	end

	// command strobes to the flash array
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cmd_q <= '0;
		else
		begin
			// byte program leaves the page open
			cmd_q.prog <= cpu_ok || dbg_ok;
			cmd_q.erase <= erase_ok;
			cmd_q.mass <= mass_ok;
			if (cpu_ok)
			begin
				cmd_q.addr <= cpu_prog_i.addr;
				cmd_q.data <= cpu_prog_i.data;
			end
			else if (dbg_ok)
			begin
				cmd_q.addr <= dbg_prog_i.addr;
				cmd_q.data <= dbg_prog_i.data;
			end
			else if (erase_ok)
				cmd_q.addr <= page_base;
			else if (mass_ok)
				cmd_q.addr <= 16'h0000;
		end
	end

	// info area map follows bit seven
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			info_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			info_q <= page_q[fpc_pkg::FPC_INFO_BIT];
			busy_q <= trk_busy;
		end
	end

	assign rdata_o = rdata_q;
	assign cmd_o = cmd_q;
	assign info_map_o = info_q;
	assign busy_o = busy_q;

	// checks
	sequence s_prot_open;
		wr_ctrl && state_q == fpc_pkg::FPC_KEY1 && bus_i.wdata == fpc_pkg::FPC_KEY_PROT;
	endsequence

	a_erase_on_key: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_ctrl && bus_i.wdata == fpc_pkg::FPC_CMD_ERASE && state_q == fpc_pkg::FPC_OPEN
		&& !page_prot && !trk_busy && !cpu_prog_i.req && !dbg_prog_i.req
		|=> cmd_q.erase && cmd_q.addr == $past(page_base))
		else $error("page erase not started");

	a_one_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$onehot0({cmd_q.prog, cmd_q.erase, cmd_q.mass}))
		else $error("two operations started together");

	a_bad_value_locks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_ctrl && bus_i.wdata != fpc_pkg::FPC_KEY_FIRST && bus_i.wdata != fpc_pkg::FPC_KEY_SECOND
		&& bus_i.wdata != fpc_pkg::FPC_KEY_PROT |=> state_q == fpc_pkg::FPC_LOCKED)
		else $error("unknown control value did not lock");

	a_mass_debug_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cmd_q.mass |-> $past(dbg_mass_i))
		else $error("mass erase without debug request");

	a_prog_stays_open: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cpu_ok && !bus_i.wr |=> cmd_q.prog && state_q == fpc_pkg::FPC_OPEN)
		else $error("byte program closed the page");

	a_ctrl_relocks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_ctrl && state_q == fpc_pkg::FPC_OPEN |=> state_q == fpc_pkg::FPC_LOCKED)
		else $error("open page not relocked");

	a_protect_steer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_prot_open ##1 (wr_page && !wr_ctrl)[*1] |=> prot_q == $past(bus_i.wdata)
		&& page_q == $past(page_q, 2))
		else $error("protect selection not honoured");

	a_protect_blocks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cpu_prog_i.req && cpu_prot && !dbg_prog_i.req |=> !cmd_q.prog)
		else $error("protected sector programmed by core");

	a_debug_prog: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		dbg_prog_i.req && !trk_busy && !cpu_prog_i.req |=> cmd_q.prog
		&& cmd_q.addr == $past(dbg_prog_i.addr))
		else $error("debug program refused");

	a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rd_ctrl && !trk_busy && state_q == fpc_pkg::FPC_KEY2 |=> rdata_q == 8'h02)
		else $error("lock progress code wrong");

	a_page_mismatch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_page && !wr_ctrl && state_q == fpc_pkg::FPC_KEY2 && bus_i.wdata != page_q
		|=> state_q == fpc_pkg::FPC_LOCKED ##1 state_q != fpc_pkg::FPC_OPEN)
		else $error("page mismatch unlocked the controller");

endmodule

`default_nettype wire

//--- fpc_array_model.sv
// flash array stand-in: answers each command strobe with a done pulse
// assumes the controller's command strobes are one cycle wide on sys_clk_i
`default_nettype none

module fpc_array_model (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_n_i, // async reset, active low
	input wire fpc_pkg::fpc_cmd_type cmd_i, // command strobes from the controller
	input wire logic [7:0] delay_i, // cycles from strobe to done, at least 1
	output logic done_o // one-cycle finish pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] left_q; // cycles still to run, 0 when idle

	// load on every strobe, count down, pulse done on the last cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			left_q <= 8'h00;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= (left_q == 8'h01);
			// a new strobe restarts the count
			if (cmd_i.prog || cmd_i.erase || cmd_i.mass)
				left_q <= delay_i;
			else if (left_q != 8'h00)
				left_q <= left_q - 8'h01;
		end
	end
endmodule

`default_nettype wire

//--- test_fpc_controller.sv
// self-checking bench for the flash program/erase controller
// assumes fpc_pkg, fpc_controller and fpc_array_model are compiled first
`default_nettype none

module test_fpc_controller;
	timeunit 1ns;
	timeprecision 1ps;

	// one bus access of the table: read compares data, write drives it
	typedef struct packed {
		logic rd;
		logic [11:0] addr;
		logic [7:0] data;
	} fpc_row_type;

	logic sys_clk_i; // 100 MHz clock
	logic rst_n_i; // async reset, active low
	fpc_pkg::fpc_bus_type bus_i; // register port
	logic [7:0] rdata_o; // read data
	fpc_pkg::fpc_prog_type cpu_prog_i; // core program request
	fpc_pkg::fpc_prog_type dbg_prog_i; // debugger program request
	logic dbg_mass_i; // debugger whole-array erase
	logic flash_done_i; // from the array model
	fpc_pkg::fpc_cmd_type cmd_o; // strobes to the array
	logic info_map_o; // info area mapped
	logic busy_o; // operation running
	logic [7:0] delay; // array answer delay
	int err_total; // mismatches
	int checks; // comparisons made
	int cycles; // timeout counter
	fpc_row_type rows [19]; // ordinary register cases

	fpc_controller #(.MEM_BYTES(8192), .PAGE_BYTES(512)) dut (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .cpu_prog_i(cpu_prog_i),
		.dbg_prog_i(dbg_prog_i), .dbg_mass_i(dbg_mass_i), .flash_done_i(flash_done_i),
		.cmd_o(cmd_o), .info_map_o(info_map_o), .busy_o(busy_o));

	fpc_array_model array (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_o),
		.delay_i(delay), .done_o(flash_done_i));

	// free-running clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t ns: %s, seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	// one-cycle register write
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk_i);
		bus_i <= '0;
	endtask

	// one-cycle register read, data compared in the following cycle
	task automatic bus_rd(input logic [11:0] a, input logic [7:0] e, input string m);
		@(posedge sys_clk_i);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk_i);
		bus_i <= '0;
		#1;
		check(16'(rdata_o), 16'(e), m);
	endtask

	// page, two unlock values, same page again
	task automatic unlock(input logic [7:0] p);
		bus_wr(fpc_pkg::FPC_ADDR_PAGE, p);
		bus_wr(fpc_pkg::FPC_ADDR_CTRL, fpc_pkg::FPC_KEY_FIRST);
		bus_wr(fpc_pkg::FPC_ADDR_CTRL, fpc_pkg::FPC_KEY_SECOND);
		bus_wr(fpc_pkg::FPC_ADDR_PAGE, p);
	endtask

	// one-cycle request: 0 core program, 1 debug program, 2 mass erase
	task automatic pulse_req(input int which, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		if (which == 0)
			cpu_prog_i <= '{req: 1'b1, addr: a, data: d};
		else if (which == 1)
			dbg_prog_i <= '{req: 1'b1, addr: a, data: d};
		else
			dbg_mass_i <= 1'b1;
		@(posedge sys_clk_i);
		cpu_prog_i.req <= 1'b0;
		dbg_prog_i.req <= 1'b0;
		dbg_mass_i <= 1'b0;
	endtask

	// strobes {prog,erase,mass} one cycle after the request, address when one fired
	task automatic look_cmd(input logic [2:0] s, input logic [15:0] a, input string m);
		#1;
		check(16'({cmd_o.prog, cmd_o.erase, cmd_o.mass}), 16'(s), m);
		if (s != 3'b000)
			check(cmd_o.addr, a, m);
	endtask

	// bounded wait for the running operation to end
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		while (busy_o !== 1'b0 && n < 200)
		begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check(16'(n), 16'(n % 200), "busy never cleared");
	endtask

	// hang guard
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_total++;
			give_verdict();
		end
	end

	// main sequence
	initial
	begin
		err_total = 0;
		checks = 0;
		cycles = 0;
		rst_n_i = 1'b0;
		bus_i = '0;
		cpu_prog_i = '0;
		dbg_prog_i = '0;
		dbg_mass_i = 1'b0;
		delay = 8'h14;
		rows = '{'{1'b1, 12'hff8, 8'h00}, '{1'b0, 12'hff9, 8'h05}, '{1'b0, 12'hff8, 8'h73},
			'{1'b1, 12'hff8, 8'h01}, '{1'b0, 12'hff8, 8'h8c}, '{1'b1, 12'hff8, 8'h02},
			'{1'b0, 12'hff9, 8'h06}, '{1'b1, 12'hff8, 8'h00}, '{1'b1, 12'hff9, 8'h06},
			'{1'b0, 12'hff8, 8'h73}, '{1'b0, 12'hff8, 8'h12}, '{1'b1, 12'hff8, 8'h00},
			'{1'b0, 12'hff8, 8'h73}, '{1'b0, 12'hff8, 8'h5e}, '{1'b1, 12'hff8, 8'h04},
			'{1'b0, 12'hff9, 8'h01}, '{1'b1, 12'hff8, 8'h00}, '{1'b1, 12'hff9, 8'h06},
			'{1'b1, 12'hff0, 8'h00}};
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		// table: lock progress, mismatched page, bad key, protect selection
		foreach (rows[i])
		begin
			if (rows[i].rd)
				bus_rd(rows[i].addr, rows[i].data, "register table row");
			else
				bus_wr(rows[i].addr, rows[i].data);
		end
		$display("test table done");
		// program twice on an open page, other page refused, then erase
		unlock(8'h06);
		pulse_req(0, 16'h0c10, 8'ha5);
		look_cmd(3'b100, 16'h0c10, "first program");
		check(16'(cmd_o.data), 16'h00a5, "program byte");
		bus_rd(12'hff8, 8'h08, "status while programming");
		check(16'(busy_o), 16'h0001, "busy while programming");
		wait_idle();
		bus_rd(12'hff8, 8'h03, "page open after program");
		pulse_req(0, 16'h0c11, 8'h5a);
		look_cmd(3'b100, 16'h0c11, "second program");
		wait_idle();
		pulse_req(0, 16'h0e00, 8'h11);
		look_cmd(3'b000, 16'h0000, "program off page");
		bus_wr(12'hff8, 8'h95);
		look_cmd(3'b010, 16'h0c00, "page erase");
		bus_rd(12'hff8, 8'h10, "status while erasing");
		wait_idle();
		bus_rd(12'hff8, 8'h00, "locked after erase");
		unlock(8'h06);
		bus_wr(12'hff8, 8'h73);
		pulse_req(0, 16'h0c00, 8'h22);
		look_cmd(3'b000, 16'h0000, "program after relock");
		$display("test program and erase done");
		// sector 0 protected: pages 0 and 1 blocked, page 2 free, debug unaffected
		delay = 8'h01;
		unlock(8'h01);
		pulse_req(0, 16'h0200, 8'h33);
		look_cmd(3'b000, 16'h0000, "program protected");
		bus_wr(12'hff8, 8'h95);
		look_cmd(3'b000, 16'h0000, "erase protected");
		unlock(8'h02);
		pulse_req(0, 16'h0400, 8'h44);
		look_cmd(3'b100, 16'h0400, "program next sector");
		wait_idle();
		pulse_req(1, 16'h0010, 8'h55);
		look_cmd(3'b100, 16'h0010, "debug program");
		wait_idle();
		delay = 8'h14;
		pulse_req(2, 16'h0000, 8'h00);
		look_cmd(3'b001, 16'h0000, "debug mass erase");
		bus_rd(12'hff8, 8'h20, "status while mass erasing");
		wait_idle();
		$display("test protection done");
		// info area map follows bit 7 of page choice
		bus_wr(12'hff9, 8'h86);
		@(posedge sys_clk_i);
		#1;
		check(16'(info_map_o), 16'h0001, "info map set");
		bus_wr(12'hff9, 8'h06);
		@(posedge sys_clk_i);
		#1;
		check(16'(info_map_o), 16'h0000, "info map clear");
		$display("test info map done");
		// reset mid-sequence: locked, protect cleared
		bus_wr(12'hff8, 8'h73);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		bus_rd(12'hff8, 8'h00, "locked after reset");
		bus_wr(12'hff8, 8'h73);
		bus_wr(12'hff8, 8'h5e);
		bus_rd(12'hff9, 8'h00, "protect after reset");
		bus_wr(12'hff9, 8'h00);
		$display("test reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
